// *** common/prio_regs_defines.svh ***
// constants for the upper interrupt priority register bank
`ifndef PRIO_REGS_DEFINES_SVH
`define PRIO_REGS_DEFINES_SVH

// ==========================================
// field and word geometry
`define PRIO_W 3
`define WORD_W 16
`define REG_ADDR_W 5
`define NUM_SOURCES 14
`define PRIO_RESET 3'h4
`define PRIO_OFF 3'h0
`define PRIO_TOP 3'h7
`define PRIO_BOTTOM 3'h1

// ==========================================
// register addresses (word index on the register port)
`define ADDR_SERIAL_TIMER 5'h07
`define ADDR_SPI2 5'h08
`define ADDR_CAPTURE3 5'h09
`define ADDR_I2C2 5'h0c
`define ADDR_RTC 5'h0f
`define ADDR_CRC_ERR 5'h10
`define ADDR_VOLTAGE 5'h12

// ==========================================
// field positions (lowest bit of each 3-bit field)
`define SERIAL2_TX_LSB 12
`define SERIAL2_RX_LSB 8
`define EXT_IRQ2_LSB 4
`define TIMER5_LSB 0
`define SPI2_EVENT_LSB 4
`define SPI2_FAULT_LSB 0
`define CAPTURE3_LSB 4
`define I2C2_MASTER_LSB 8
`define I2C2_SLAVE_LSB 4
`define CALENDAR_LSB 8
`define CHECKSUM_ERR_LSB 12
`define SERIAL2_ERR_LSB 8
`define SERIAL1_ERR_LSB 4
`define VOLTAGE_DETECT_LSB 0

`endif

// *** common/prio_regs_pkg.sv ***
// types shared by the upper interrupt priority register bank
`default_nettype none
`include "prio_regs_defines.svh"

package prio_regs_pkg;
   // ==========================================
   // field, word and vector types
   typedef logic [`PRIO_W-1:0] prio_t;
   typedef logic [`WORD_W-1:0] reg_word_t;
   typedef logic [`REG_ADDR_W-1:0] reg_addr_t;
   typedef logic [`NUM_SOURCES-1:0] src_vec_t;
endpackage

`default_nettype wire

// *** rtl/interrupt_priority_regs_upper.sv ***
// upper interrupt priority register bank with per-source priority outputs
//
// Function
// - field is 3 bits; value 111 means priority 7, highest for peripherals.
// - value 001 means priority 1, lowest level that still requests service.
// - value 000 disables the source; it never raises a request.
// - bits outside priority fields read zero and ignore writes.
// - after any reset every source here sits at priority 4.
// - register 7: serial2 tx 14-12, rx 10-8, ext irq2 6-4, timer5 2-0.
// - register 8: spi2 event 6-4, spi2 fault 2-0, bits 15-7 and 3 unused.
// - register 9: capture3 at bits 6-4, all other bits unused.
// - register 12: i2c2 master at bits 10-8, i2c2 slave at 6-4.
// - register 15: calendar at bits 10-8, bits 15-11 and 7-0 unused.
// - register 16: checksum error 14-12, serial2 error 10-8, serial1 error 6-4.
// - register 18: voltage detect at bits 2-0, bits 15-3 unused.
`timescale 1ns/10ps
`default_nettype none
`include "prio_regs_defines.svh"

module interrupt_priority_regs_upper (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register port
   input wire prio_regs_pkg::reg_addr_t reg_addr,
   input wire prio_regs_pkg::reg_word_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output prio_regs_pkg::reg_word_t reg_rdata,
   // pending sources (flag and enable already combined)
   input wire prio_regs_pkg::src_vec_t src_pending,
   // gated requests toward the arbiter
   output prio_regs_pkg::src_vec_t src_req,
   // per-source priority levels
   output prio_regs_pkg::prio_t serial2_tx_prio,
   output prio_regs_pkg::prio_t serial2_rx_prio,
   output prio_regs_pkg::prio_t ext_irq2_prio,
   output prio_regs_pkg::prio_t timer5_prio,
   output prio_regs_pkg::prio_t spi2_event_prio,
   output prio_regs_pkg::prio_t spi2_fault_prio,
   output prio_regs_pkg::prio_t capture3_prio,
   output prio_regs_pkg::prio_t i2c2_master_prio,
   output prio_regs_pkg::prio_t i2c2_slave_prio,
   output prio_regs_pkg::prio_t calendar_prio,
   output prio_regs_pkg::prio_t checksum_err_prio,
   output prio_regs_pkg::prio_t serial2_err_prio,
   output prio_regs_pkg::prio_t serial1_err_prio,
   output prio_regs_pkg::prio_t voltage_detect_prio
);

   // ==========================================
   // source map: word address and field position per source
   localparam prio_regs_pkg::reg_addr_t SRC_ADDR [`NUM_SOURCES] = '{
      `ADDR_SERIAL_TIMER, `ADDR_SERIAL_TIMER, `ADDR_SERIAL_TIMER, `ADDR_SERIAL_TIMER,
      `ADDR_SPI2, `ADDR_SPI2, `ADDR_CAPTURE3, `ADDR_I2C2, `ADDR_I2C2, `ADDR_RTC,
      `ADDR_CRC_ERR, `ADDR_CRC_ERR, `ADDR_CRC_ERR, `ADDR_VOLTAGE};
   localparam int SRC_LSB [`NUM_SOURCES] = '{
      `SERIAL2_TX_LSB, `SERIAL2_RX_LSB, `EXT_IRQ2_LSB, `TIMER5_LSB,
      `SPI2_EVENT_LSB, `SPI2_FAULT_LSB, `CAPTURE3_LSB, `I2C2_MASTER_LSB,
      `I2C2_SLAVE_LSB, `CALENDAR_LSB, `CHECKSUM_ERR_LSB, `SERIAL2_ERR_LSB,
      `SERIAL1_ERR_LSB, `VOLTAGE_DETECT_LSB};

   // ==========================================
   // reset release: async assert, two-stage synchronous release
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ==========================================
   // priority fields, one per source
   prio_regs_pkg::prio_t prio_d [`NUM_SOURCES];
   prio_regs_pkg::prio_t prio_q [`NUM_SOURCES];
   prio_regs_pkg::src_vec_t req_d;
   prio_regs_pkg::src_vec_t req_q;

   genvar gi;
   generate
      for (gi = 0; gi < `NUM_SOURCES; gi++) begin : g_src
         // only the three field bits are stored; other word bits have no flop
         always_comb begin
            prio_d[gi] = prio_q[gi];
            if (reg_wr && (reg_addr == SRC_ADDR[gi])) begin
               prio_d[gi] = reg_wdata[SRC_LSB[gi] +: `PRIO_W];
            end
            // level equals the field value; zero blocks the request
            req_d[gi] = src_pending[gi] && (prio_q[gi] != `PRIO_OFF);
         end

         // every reset comes through the synchronised copy
         always_ff @(posedge clk_sys or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
               prio_q[gi] <= `PRIO_RESET;
            end else begin
               prio_q[gi] <= prio_d[gi];
            end
         end
      end
   endgenerate

   // request register; one cycle behind pending, keeps outputs glitch free
   always_ff @(posedge clk_sys or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         req_q <= '0;
      end else begin
         req_q <= req_d;
      end
   end

   // ==========================================
   // read path: data stands only in the cycle after the strobe
   prio_regs_pkg::reg_word_t rdata_d;
   prio_regs_pkg::reg_word_t rdata_q;

   // unmapped address and unused bits stay zero
   always_comb begin
      rdata_d = '0;
      if (reg_rd) begin
         for (int i = 0; i < `NUM_SOURCES; i++) begin
            if (reg_addr == SRC_ADDR[i]) begin
               rdata_d[SRC_LSB[i] +: `PRIO_W] = prio_q[i];
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ==========================================
   // outputs, all straight from flops
   assign reg_rdata = rdata_q;
   assign src_req = req_q;
   assign serial2_tx_prio = prio_q[0];
   assign serial2_rx_prio = prio_q[1];
   assign ext_irq2_prio = prio_q[2];
   assign timer5_prio = prio_q[3];
   assign spi2_event_prio = prio_q[4];
   assign spi2_fault_prio = prio_q[5];
   assign capture3_prio = prio_q[6];
   assign i2c2_master_prio = prio_q[7];
   assign i2c2_slave_prio = prio_q[8];
   assign calendar_prio = prio_q[9];
   assign checksum_err_prio = prio_q[10];
   assign serial2_err_prio = prio_q[11];
   assign serial1_err_prio = prio_q[12];
   assign voltage_detect_prio = prio_q[13];

   // ==========================================
   // checks: helper mask of implemented bits at the read address
   prio_regs_pkg::reg_word_t impl_mask;

   always_comb begin
      impl_mask = '0;
      for (int i = 0; i < `NUM_SOURCES; i++) begin
         if (reg_addr == SRC_ADDR[i]) begin
            impl_mask[SRC_LSB[i] +: `PRIO_W] = {`PRIO_W{1'b1}};
         end
      end
   end

   // any read leaves unused bits at zero
   chk_unused_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_sync_q)
      reg_rd |=> ((reg_rdata & ~$past(impl_mask)) == '0))
      else $error("unused register bit read back nonzero");

   // an address with no field answers all zero
   chk_unmapped_read: assert property (
      @(posedge clk_sys) disable iff (!rst_sync_q)
      (reg_rd && (impl_mask == '0)) |=> (reg_rdata == '0))
      else $error("unmapped address read back nonzero");

   // idle cycles leave the read data at zero
   chk_idle_rdata: assert property (
      @(posedge clk_sys) disable iff (!rst_sync_q)
      !reg_rd |=> (reg_rdata == '0))
      else $error("read data present without a read strobe");

   // all fields side by side, for checks that watch the whole bank
   logic [`NUM_SOURCES*`PRIO_W-1:0] prio_flat;

   always_comb begin
      prio_flat = '0;
      for (int i = 0; i < `NUM_SOURCES; i++) begin
         prio_flat[i*`PRIO_W +: `PRIO_W] = prio_q[i];
      end
   end

   // leaving reset: nothing carried over, no request and no read data
   chk_reset_quiet: assert property (
      @(posedge clk_sys) disable iff (!rst_sync_q)
      $rose(rst_sync_q) |-> ((src_req == '0) && (reg_rdata == '0)))
      else $error("request or read data left over from reset");

   // leaving reset: the whole bank sits at level four
   chk_bank_reset: assert property (
      @(posedge clk_sys) disable iff (!rst_sync_q)
      $rose(rst_sync_q) |-> (prio_flat == {`NUM_SOURCES{`PRIO_RESET}}))
      else $error("bank not at level four after reset");

   // a word with no field takes a write without moving any priority
   chk_unmapped_write: assert property (
      @(posedge clk_sys) disable iff (!rst_sync_q)
      (reg_wr && (impl_mask == '0)) |=> $stable(prio_flat))
      else $error("write to an unmapped word changed a priority");

   generate
      for (gi = 0; gi < `NUM_SOURCES; gi++) begin : g_chk
         // a write to this field's word, then the field carries the value
         sequence s_field_write;
            reg_wr && (reg_addr == SRC_ADDR[gi]);
         endsequence

         sequence s_field_write_val(logic [`PRIO_W-1:0] v);
            reg_wr && (reg_addr == SRC_ADDR[gi])
               && (reg_wdata[SRC_LSB[gi] +: `PRIO_W] == v);
         endsequence

         sequence s_field_read;
            reg_rd && (reg_addr == SRC_ADDR[gi]);
         endsequence

         // write, one cycle without a write to the word, then a read of it
         sequence s_write_gap_read;
            s_field_write ##1 !(reg_wr && (reg_addr == SRC_ADDR[gi])) ##1 s_field_read;
         endsequence

         // first cycle out of reset shows level four
         chk_reset_level: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            $rose(rst_sync_q) |-> (prio_q[gi] == `PRIO_RESET))
            else $error("priority field not at level four after reset");

         chk_field_write: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            s_field_write |=> (prio_q[gi] == $past(reg_wdata[SRC_LSB[gi] +: `PRIO_W])))
            else $error("priority field did not take written value");

         // field holds when its word is not written
         chk_field_hold: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            !(reg_wr && (reg_addr == SRC_ADDR[gi])) |=> $stable(prio_q[gi]))
            else $error("priority field changed without a write");

         chk_field_read: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            (reg_rd && (reg_addr == SRC_ADDR[gi]))
               |=> (reg_rdata[SRC_LSB[gi] +: `PRIO_W] == $past(prio_q[gi])))
            else $error("priority field read from wrong bits");

         // level seven written, then a pending source requests two cycles on
         chk_top_level: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            s_field_write_val(`PRIO_TOP) ##1 src_pending[gi] |=> src_req[gi])
            else $error("level seven source did not request");

         chk_bottom_level: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            s_field_write_val(`PRIO_BOTTOM) ##1 src_pending[gi] |=> src_req[gi])
            else $error("level one source did not request");

         chk_disable_gate: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            (prio_q[gi] == `PRIO_OFF) |=> !src_req[gi])
            else $error("disabled source raised a request");

         chk_mid_level: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            (src_pending[gi] && (prio_q[gi] != `PRIO_OFF)) |=> src_req[gi])
            else $error("enabled pending source did not request");

         // software gets back what it wrote, read data one cycle after the read
         chk_write_readback: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            s_write_gap_read |=> (reg_rdata[SRC_LSB[gi] +: `PRIO_W]
               == $past(reg_wdata[SRC_LSB[gi] +: `PRIO_W], 3)))
            else $error("priority field did not read back the written value");

         // zero written, then a pending source stays silent
         chk_zero_silent: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            s_field_write_val(`PRIO_OFF) ##1 src_pending[gi] |=> !src_req[gi])
            else $error("source written to zero still requested");

         // no pending source, no request, whatever its level
         chk_req_needs_pending: assert property (
            @(posedge clk_sys) disable iff (!rst_sync_q)
            !src_pending[gi] |=> !src_req[gi])
            else $error("request raised without a pending source");
      end
   endgenerate

endmodule

`default_nettype wire

// *** testbench/tb_interrupt_priority_regs_upper.sv ***
// self-checking bench for the upper interrupt priority register bank
`timescale 1ns/10ps
`default_nettype none
`include "prio_regs_defines.svh"

module tb_interrupt_priority_regs_upper;
   // ==========================================
   // signals
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   prio_regs_pkg::reg_addr_t reg_addr = '0;
   prio_regs_pkg::reg_word_t reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   prio_regs_pkg::reg_word_t reg_rdata, rd_val;
   prio_regs_pkg::src_vec_t src_pending = '0;
   prio_regs_pkg::src_vec_t src_req;
   prio_regs_pkg::prio_t serial2_tx_prio, serial2_rx_prio, ext_irq2_prio, timer5_prio;
   prio_regs_pkg::prio_t spi2_event_prio, spi2_fault_prio, capture3_prio, i2c2_master_prio;
   prio_regs_pkg::prio_t i2c2_slave_prio, calendar_prio, checksum_err_prio, serial2_err_prio;
   prio_regs_pkg::prio_t serial1_err_prio, voltage_detect_prio;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   // word addresses, implemented bits and a distinct field pattern per word
   prio_regs_pkg::reg_addr_t addrs [7] = '{`ADDR_SERIAL_TIMER, `ADDR_SPI2, `ADDR_CAPTURE3,
      `ADDR_I2C2, `ADDR_RTC, `ADDR_CRC_ERR, `ADDR_VOLTAGE};
   prio_regs_pkg::reg_word_t masks [7] = '{16'h7777, 16'h0077, 16'h0070, 16'h0770,
      16'h0700, 16'h7770, 16'h0007};
   prio_regs_pkg::reg_word_t pats [7] = '{16'h7531, 16'h0062, 16'h0050, 16'h0340,
      16'h0700, 16'h5210, 16'h0006};

   interrupt_priority_regs_upper i_dut (
      .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .src_pending, .src_req, .serial2_tx_prio, .serial2_rx_prio, .ext_irq2_prio,
      .timer5_prio, .spi2_event_prio, .spi2_fault_prio, .capture3_prio,
      .i2c2_master_prio, .i2c2_slave_prio, .calendar_prio, .checksum_err_prio,
      .serial2_err_prio, .serial1_err_prio, .voltage_detect_prio);

   // ==========================================
   // clock and hang guard, ceiling well above the roughly 150 cycles needed
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors = errors + 1;
         give_verdict();
      end
   end

   // all priority outputs packed, source 0 in the low bits
   function automatic logic [41:0] prio_vec();
      return {voltage_detect_prio, serial1_err_prio, serial2_err_prio, checksum_err_prio,
         calendar_prio, i2c2_slave_prio, i2c2_master_prio, capture3_prio, spi2_fault_prio,
         spi2_event_prio, timer5_prio, ext_irq2_prio, serial2_rx_prio, serial2_tx_prio};
   endfunction

   // ==========================================
   // access and compare tasks
   task automatic wr(input prio_regs_pkg::reg_addr_t a, input prio_regs_pkg::reg_word_t d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask

   // data sampled one step after the edge that took the strobe
   task automatic rd(input prio_regs_pkg::reg_addr_t a, output prio_regs_pkg::reg_word_t d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic cmp_word(input string n, input prio_regs_pkg::reg_word_t e,
                           input prio_regs_pkg::reg_word_t g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_vec(input string n, input logic [41:0] e, input logic [41:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // every word read back as fill limited to its implemented bits
   task automatic sweep(input prio_regs_pkg::reg_word_t fill);
      for (int i = 0; i < 7; i++) begin
         rd(addrs[i], rd_val);
         cmp_word("word", fill & masks[i], rd_val);
      end
   endtask

   task automatic give_verdict();
      $display("counts: checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================
   // test sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      cmp_vec("prio_reset", {14{3'h4}}, prio_vec());
      sweep(16'h4444);
      $display("test reset values done");

      // every field code on all four fields of register 7, timer5 output level equal to the code
      for (int v = 0; v < 8; v++) begin
         wr(`ADDR_SERIAL_TIMER, {4{1'b0, v[2:0]}});
         cmp_vec("timer5", {39'h0, v[2:0]}, {39'h0, timer5_prio});
         rd(`ADDR_SERIAL_TIMER, rd_val);
         cmp_word("codes", {4{1'b0, v[2:0]}}, rd_val);
      end
      @(posedge clk_sys);
      #1;
      cmp_word("rdata_idle", 16'h0000, reg_rdata);
      $display("test field codes done");

      // all ones: unused bits stay zero; unmapped word reads zero
      for (int i = 0; i < 7; i++) wr(addrs[i], 16'hffff);
      sweep(16'hffff);
      wr(5'h0a, 16'hffff);
      rd(5'h0a, rd_val);
      cmp_word("unmapped", 16'h0000, rd_val);
      $display("test unused bits done");

      // distinct pattern per word, checked at the priority outputs
      for (int i = 0; i < 7; i++) wr(addrs[i], pats[i]);
      cmp_vec("prio_map", {3'h6, 3'h1, 3'h2, 3'h5, 3'h7, 3'h4, 3'h3, 3'h5, 3'h2, 3'h6,
         3'h1, 3'h3, 3'h5, 3'h7}, prio_vec());
      $display("test field map done");

      // pending raised first; timer5 requests at level one, then drops once written to zero
      @(posedge clk_sys);
      src_pending <= 14'h3fff;
      wr(`ADDR_SERIAL_TIMER, 16'h7510);
      cmp_vec("req_pre", 42'h3fff, {28'h0, src_req});
      @(posedge clk_sys);
      #1;
      cmp_vec("req_on", 42'h3ff7, {28'h0, src_req});
      @(posedge clk_sys);
      src_pending <= 14'h0000;
      @(posedge clk_sys);
      #1;
      cmp_vec("req_off", 42'h0, {28'h0, src_req});
      $display("test request gating done");

      // second reset in mid-run, taken while requests stand
      @(posedge clk_sys);
      src_pending <= 14'h3fff;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b0;
      #1;
      cmp_vec("prio_rerst", {14{3'h4}}, prio_vec());
      cmp_vec("req_rerst", 42'h0, {28'h0, src_req});
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sweep(16'h4444);
      cmp_vec("req_lvl4", 42'h3fff, {28'h0, src_req});
      $display("test second reset done");
      give_verdict();
   end
endmodule

`default_nettype wire
